// *** rtl/hrad_dev_end.sv ***
// device end: decodes memory and io windows onto registers and external flash
`timescale 1ns/100ps
// Contract
// RQ1 - decode 128 KB register and memory window
// RQ2 - flash and expansion windows reach one flash
// RQ3 - 8-byte io window, indirect access
// RQ4 - registers 32 bits on 64-bit alignment
// RQ5 - io pointer and data on 32-bit offsets
// RQ6 - flash accepts byte to quadword sizes
// RQ7 - host never sets reserved bits (host end masks them in memory window only; io data writes pass them)
// RQ8 - host never writes undefined addresses (refused in memory window only; io data writes go at any pointer)
// RQ9 - load or hardware update supersedes defaults
// RQ10 - partial register writes are discarded
// RQ11 - partial reads return whole register
// RQ12 - host avoids partial reads of read-clear (host end widens lanes on memory-window reads only, not on io data reads)
// RQ13 - statistics 64-bit access keeps upper lanes off
// RQ14 - no 64-bit access to unaligned register
// RQ15 - phy registers not mapped on bus
// RQ16 - registers are offsets from first base
// RQ17 - flash window needs enable and base
// RQ18 - flash offset passes unchanged
// RQ19 - expansion window needs enable and base
// RQ20 - undefined offsets read zero, drop writes
module hrad_dev_end #(
    parameter int FLASH_AW = hrad_pkg::FLASH_AW_MAX
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    hrad_if.dev BUS,
    input wire logic [31:0] CFG_REG_BASE,
    input wire logic [31:0] CFG_FLASH_BASE,
    input wire logic [31:0] CFG_EROM_BASE,
    input wire logic [31:0] CFG_IO_BASE,
    input wire logic CFG_FLASH_EN,
    input wire logic CFG_EROM_EN,
    input wire logic LOAD_VALID,
    input wire logic [hrad_pkg::REG_IDX_W-1:0] LOAD_IDX,
    input wire logic [31:0] LOAD_DATA,
    input wire logic [31:0] CAUSE_SET,
    output logic CAUSE_PENDING,
    output logic [31:0] CTRL_WORD,
    output logic FLASH_REQ,
    output logic FLASH_WE,
    output logic [FLASH_AW-1:0] FLASH_ADDR,
    output logic [7:0] FLASH_BE,
    output logic [63:0] FLASH_WDATA,
    input wire logic [63:0] FLASH_RDATA,
    input wire logic FLASH_DONE
);
    typedef enum logic [0:0] {D_IDLE, D_FLASH} hrad_dst_t;

    typedef struct packed {
        hrad_dst_t st;
        logic ack;
        logic claimed;
        logic [63:0] rdata;
        logic [hrad_pkg::IO_PTR_W-1:0] ptr;
        logic [hrad_pkg::NREG-1:0][31:0] regs;
        logic cause_pending;
        logic io_fl;
        logic fl_req;
        logic fl_we;
        logic [FLASH_AW-1:0] fl_addr;
        logic [7:0] fl_be;
        logic [63:0] fl_wdata;
    } hrad_dstate_t;

    hrad_dstate_t s;
    hrad_dstate_t n;

    logic reg_hit;
    logic fl_hit;
    logic er_hit;
    logic io_hit;
    logic acc_go;
    logic acc_we;
    logic acc_full;
    logic acc_io;
    logic [hrad_pkg::REG_WIN_AW-1:0] acc_off;
    logic [31:0] acc_wd;
    logic [31:0] rd;
    logic [hrad_pkg::REG_IDX_W-1:0] idx;
    logic [hrad_pkg::IO_PTR_W-1:0] io_fl_off;

    always_comb begin
        n = s;
        n.ack = 1'b0;
        acc_go = 1'b0;
        acc_we = 1'b0;
        acc_full = 1'b0;
        acc_io = 1'b0;
        acc_off = '0;
        acc_wd = hrad_pkg::DW_ZERO;
        rd = hrad_pkg::DW_ZERO;
        idx = '0;
        io_fl_off = s.ptr - hrad_pkg::IO_FLASH_BASE;
        // phy registers get no window of their own [RQ15]
        reg_hit = hrad_pkg::win_hit(BUS.addr, CFG_REG_BASE, hrad_pkg::REG_WIN_AW); // [RQ1] [RQ16]
        fl_hit = CFG_FLASH_EN && (CFG_FLASH_BASE != 32'h0000_0000)
            && hrad_pkg::win_hit(BUS.addr, CFG_FLASH_BASE, FLASH_AW); // [RQ17]
        er_hit = CFG_EROM_EN && (CFG_EROM_BASE != 32'h0000_0000)
            && hrad_pkg::win_hit(BUS.addr, CFG_EROM_BASE, FLASH_AW); // [RQ19]
        io_hit = (CFG_IO_BASE != 32'h0000_0000)
            && hrad_pkg::win_hit(BUS.addr, CFG_IO_BASE, hrad_pkg::IO_WIN_AW); // [RQ3]
        case (s.st)
            D_IDLE: begin
                if (BUS.req && !s.ack) begin
                    n.ack = 1'b1;
                    n.claimed = 1'b0;
                    n.rdata = '0;
                    if (BUS.space == hrad_pkg::HRAD_SPACE_IO && io_hit) begin
                        n.claimed = 1'b1;
                        if (BUS.addr[2:0] == hrad_pkg::IO_PTR_OFF) begin // [RQ5]
                            if (!BUS.we) begin
                                n.rdata[31:0] = {12'h000, s.ptr};
                            end else if (BUS.be[3:0] == hrad_pkg::BE_FULL_DW) begin
                                n.ptr = BUS.wdata[hrad_pkg::IO_PTR_W-1:0];
                            end
                        end else if (BUS.addr[2:0] == hrad_pkg::IO_DATA_OFF) begin // [RQ5]
                            if (s.ptr < hrad_pkg::IO_UNDEF_BASE) begin
                                acc_go = 1'b1;
                                acc_io = 1'b1;
                                acc_we = BUS.we;
                                acc_full = (BUS.be[7:4] == hrad_pkg::BE_FULL_DW);
                                acc_off = s.ptr[hrad_pkg::REG_WIN_AW-1:0];
                                acc_wd = BUS.wdata[63:32];
                            end else if (s.ptr >= hrad_pkg::IO_FLASH_BASE) begin // [RQ3]
                                n.ack = 1'b0;
                                n.st = D_FLASH;
                                n.io_fl = 1'b1;
                                n.fl_req = 1'b1;
                                n.fl_we = BUS.we;
                                n.fl_addr = io_fl_off[FLASH_AW-1:0];
                                n.fl_be = s.ptr[2] ? {BUS.be[7:4], hrad_pkg::BE_NONE}
                                                   : {hrad_pkg::BE_NONE, BUS.be[7:4]};
                                n.fl_wdata = {BUS.wdata[63:32], BUS.wdata[63:32]};
                            end
                        end
                    end else if (BUS.space == hrad_pkg::HRAD_SPACE_MEM && reg_hit) begin
                        n.claimed = 1'b1;
                        acc_go = 1'b1;
                        acc_we = BUS.we;
                        acc_full = (BUS.be[3:0] == hrad_pkg::BE_FULL_DW);
                        acc_off = BUS.addr[hrad_pkg::REG_WIN_AW-1:0];
                        acc_wd = BUS.wdata[31:0];
                    end else if (BUS.space == hrad_pkg::HRAD_SPACE_MEM
                                 && (fl_hit || er_hit)) begin // [RQ2]
                        n.claimed = 1'b1;
                        n.ack = 1'b0;
                        n.st = D_FLASH;
                        n.io_fl = 1'b0;
                        n.fl_req = 1'b1;
                        n.fl_we = BUS.we;
                        n.fl_addr = BUS.addr[FLASH_AW-1:0]; // [RQ18]
                        n.fl_be = BUS.be; // [RQ6]
                        n.fl_wdata = BUS.wdata;
                    end
                end
            end
            D_FLASH: begin
                if (FLASH_DONE) begin
                    n.fl_req = 1'b0;
                    n.ack = 1'b1;
                    n.st = D_IDLE;
                    if (s.io_fl) begin
                        n.rdata = {s.fl_addr[2] ? FLASH_RDATA[63:32] : FLASH_RDATA[31:0],
                                   hrad_pkg::DW_ZERO};
                    end else begin
                        n.rdata = FLASH_RDATA;
                    end
                end
            end
            default: begin
                n.st = D_IDLE;
            end
        endcase
        // register access shared by memory and io windows
        if (acc_go && hrad_pkg::reg_defined(acc_off)) begin // [RQ4] [RQ20]
            idx = acc_off[hrad_pkg::REG_IDX_W+2:3];
            if (acc_we) begin
                if (acc_full) begin // [RQ10]
                    n.regs[idx] = acc_wd;
                end
            end else begin
                rd = s.regs[idx]; // [RQ11]
                if (idx == hrad_pkg::RC_IDX) begin
                    n.regs[idx] = hrad_pkg::DW_ZERO;
                end
            end
            n.rdata = acc_io ? {rd, hrad_pkg::DW_ZERO} : {hrad_pkg::DW_ZERO, rd};
        end
        if (LOAD_VALID) begin
            n.regs[LOAD_IDX] = LOAD_DATA; // [RQ9]
        end
        // event set wins over the read clear
        n.regs[hrad_pkg::RC_IDX] = n.regs[hrad_pkg::RC_IDX] | CAUSE_SET;
        n.cause_pending = (n.regs[hrad_pkg::RC_IDX] != hrad_pkg::DW_ZERO);
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            s.st <= D_IDLE;
            s.ack <= 1'b0;
            s.claimed <= 1'b0;
            s.rdata <= '0;
            s.ptr <= hrad_pkg::IO_PTR_RESET;
            s.regs <= {hrad_pkg::NREG{hrad_pkg::REG_RESET}};
            s.cause_pending <= 1'b0;
            s.io_fl <= 1'b0;
            s.fl_req <= 1'b0;
            s.fl_we <= 1'b0;
            s.fl_addr <= '0;
            s.fl_be <= '0;
            s.fl_wdata <= '0;
        end else begin
            s <= n;
        end
    end

    assign BUS.ack = s.ack;
    assign BUS.claimed = s.claimed;
    assign BUS.rdata = s.rdata;
    assign CAUSE_PENDING = s.cause_pending;
    assign CTRL_WORD = s.regs[0];
    assign FLASH_REQ = s.fl_req;
    assign FLASH_WE = s.fl_we;
    assign FLASH_ADDR = s.fl_addr;
    assign FLASH_BE = s.fl_be;
    assign FLASH_WDATA = s.fl_wdata;
endmodule

// *** rtl/hrad_pkg.sv ***
// shared constants, types and decode helpers for the host register access decode
package hrad_pkg;
    localparam int REG_WIN_AW = 17;
    localparam int IO_WIN_AW = 3;
    localparam int FLASH_AW_MAX = 19;
    localparam int FLASH_AW_MIN = 16;
    localparam int NREG = 16;
    localparam int REG_IDX_W = 4;
    localparam logic [15:0] REG_DEFINED = 16'h3fff;
    localparam logic [3:0] RC_IDX = 4'h1;
    localparam logic [3:0] STAT_FIRST = 4'h8;
    localparam logic [31:0] REG_WR_MASK = 32'h00ff_ffff;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [2:0] IO_PTR_OFF = 3'h0;
    localparam logic [2:0] IO_DATA_OFF = 3'h4;
    localparam int IO_PTR_W = 20;
    localparam logic [19:0] IO_PTR_RESET = 20'h0_0000;
    localparam logic [19:0] IO_UNDEF_BASE = 20'h2_0000;
    localparam logic [19:0] IO_FLASH_BASE = 20'h8_0000;
    localparam logic [3:0] BE_FULL_DW = 4'hf;
    localparam logic [3:0] BE_NONE = 4'h0;
    localparam logic [2:0] QW_ALIGN = 3'h0;
    localparam logic [31:0] DW_ZERO = 32'h0000_0000;

    typedef enum logic {HRAD_SPACE_MEM, HRAD_SPACE_IO} hrad_space_t;

    // offset inside the register window names a defined 64-bit aligned register
    function automatic logic reg_defined(input logic [REG_WIN_AW-1:0] off);
        logic [REG_WIN_AW-4:0] idx;
        idx = off[REG_WIN_AW-1:3];
        reg_defined = (idx < (REG_WIN_AW-3)'(NREG)) && (off[2:0] == QW_ALIGN)
            && REG_DEFINED[idx[REG_IDX_W-1:0]];
    endfunction

    // address falls in a window of 2**aw bytes based at base
    function automatic logic win_hit(input logic [31:0] addr, input logic [31:0] base,
                                     input int aw);
        logic [31:0] mask;
        mask = ~((32'h0000_0001 << aw) - 32'h0000_0001);
        win_hit = ((addr & mask) == (base & mask));
    endfunction
endpackage

// *** rtl/hrad_if.sv ***
// host bus carrier between the host end and the device end
`timescale 1ns/100ps
interface hrad_if;
    logic req;
    hrad_pkg::hrad_space_t space;
    logic [31:0] addr;
    logic [7:0] be;
    logic we;
    logic [63:0] wdata;
    logic ack;
    logic claimed;
    logic [63:0] rdata;

    modport dev (
        input req,
        input space,
        input addr,
        input be,
        input we,
        input wdata,
        output ack,
        output claimed,
        output rdata
    );
    modport host (
        output req,
        output space,
        output addr,
        output be,
        output we,
        output wdata,
        input ack,
        input claimed,
        input rdata
    );
endinterface

// *** rtl/hrad_host_end.sv ***
// host end: issues bus requests and keeps the access conventions
`timescale 1ns/100ps
module hrad_host_end (
    input wire logic CLK_SYS,
    input wire logic RST,
    hrad_if.host BUS,
    input wire logic [31:0] CFG_REG_BASE,
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire hrad_pkg::hrad_space_t CMD_SPACE,
    input wire logic [31:0] CMD_ADDR,
    input wire logic [7:0] CMD_BE,
    input wire logic CMD_WRITE,
    input wire logic [63:0] CMD_WDATA,
    output logic RES_VALID,
    output logic RES_CLAIMED,
    output logic RES_REFUSED,
    output logic [63:0] RES_RDATA
);
    typedef enum logic [0:0] {H_IDLE, H_BUSY} hrad_hst_t;

    typedef struct packed {
        hrad_hst_t st;
        logic ready;
        logic req;
        hrad_pkg::hrad_space_t space;
        logic [31:0] addr;
        logic [7:0] be;
        logic we;
        logic [63:0] wdata;
        logic res_valid;
        logic res_claimed;
        logic res_refused;
        logic [63:0] res_rdata;
    } hrad_hstate_t;

    hrad_hstate_t s;
    hrad_hstate_t n;

    logic in_reg;
    logic [hrad_pkg::REG_WIN_AW-1:0] off;
    logic [7:0] be;
    logic [63:0] wd;

    always_comb begin
        n = s;
        n.res_valid = 1'b0;
        off = CMD_ADDR[hrad_pkg::REG_WIN_AW-1:0];
        in_reg = (CMD_SPACE == hrad_pkg::HRAD_SPACE_MEM)
            && hrad_pkg::win_hit(CMD_ADDR, CFG_REG_BASE, hrad_pkg::REG_WIN_AW);
        be = CMD_BE;
        wd = CMD_WDATA;
        if (in_reg) begin
            be[7:4] = hrad_pkg::BE_NONE; // [RQ13] [RQ14]
            wd[31:0] = CMD_WDATA[31:0] & hrad_pkg::REG_WR_MASK; // [RQ7]
            if (!CMD_WRITE && off[hrad_pkg::REG_IDX_W+2:3] == hrad_pkg::RC_IDX) begin
                be[3:0] = hrad_pkg::BE_FULL_DW; // [RQ12]
            end
        end
        case (s.st)
            H_IDLE: begin
                if (CMD_VALID && s.ready) begin
                    if (in_reg && CMD_WRITE && !hrad_pkg::reg_defined(off)) begin // [RQ8]
                        n.res_valid = 1'b1;
                        n.res_refused = 1'b1;
                        n.res_claimed = 1'b0;
                        n.res_rdata = '0;
                    end else begin
                        n.st = H_BUSY;
                        n.ready = 1'b0;
                        n.req = 1'b1;
                        n.space = CMD_SPACE;
                        n.addr = CMD_ADDR;
                        n.be = be;
                        n.we = CMD_WRITE;
                        n.wdata = wd;
                    end
                end
            end
            H_BUSY: begin
                if (BUS.ack) begin
                    n.st = H_IDLE;
                    n.ready = 1'b1;
                    n.req = 1'b0;
                    n.res_valid = 1'b1;
                    n.res_refused = 1'b0;
                    n.res_claimed = BUS.claimed;
                    n.res_rdata = BUS.rdata;
                end
            end
            default: begin
                n.st = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            s.st <= H_IDLE;
            s.ready <= 1'b1;
            s.req <= 1'b0;
            s.space <= hrad_pkg::HRAD_SPACE_MEM;
            s.addr <= '0;
            s.be <= '0;
            s.we <= 1'b0;
            s.wdata <= '0;
            s.res_valid <= 1'b0;
            s.res_claimed <= 1'b0;
            s.res_refused <= 1'b0;
            s.res_rdata <= '0;
        end else begin
            s <= n;
        end
    end

    assign BUS.req = s.req;
    assign BUS.space = s.space;
    assign BUS.addr = s.addr;
    assign BUS.be = s.be;
    assign BUS.we = s.we;
    assign BUS.wdata = s.wdata;
    assign CMD_READY = s.ready;
    assign RES_VALID = s.res_valid;
    assign RES_CLAIMED = s.res_claimed;
    assign RES_REFUSED = s.res_refused;
    assign RES_RDATA = s.res_rdata;
endmodule

// *** sim/hrad_props.sv ***
// concurrent checks on the carrier between host end and device end
`timescale 1ns/100ps
module hrad_props #(
    parameter logic [31:0] REG_BASE = 32'h0010_0000,
    parameter logic [31:0] IO_BASE = 32'h0000_1000
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic req,
    input wire hrad_pkg::hrad_space_t space,
    input wire logic [31:0] addr,
    input wire logic [7:0] be,
    input wire logic we,
    input wire logic [63:0] wdata,
    input wire logic ack,
    input wire logic claimed,
    input wire logic [63:0] rdata
);
    logic in_reg;
    logic in_io;
    assign in_reg = req && space == hrad_pkg::HRAD_SPACE_MEM && addr[31:17] == REG_BASE[31:17];
    assign in_io = req && space == hrad_pkg::HRAD_SPACE_IO && addr[31:3] == IO_BASE[31:3];
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    sequence s_reg_start;
        $rose(req) ##0 in_reg;
    endsequence
    sequence s_answer;
        ack ##1 !ack;
    endsequence
    a_reg_answer: assert property (s_reg_start |=> s_answer)
        else $error("register access not answered in one cycle");
    a_reg_claimed: assert property (in_reg ##1 ack |-> claimed)
        else $error("register window access not claimed");
    a_io_pointer: assert property ($rose(req) ##0 (in_io && addr[2:0] == 3'h0)
        |=> ack && claimed)
        else $error("io pointer access not answered");
    a_io_claimed: assert property (in_io ##1 ack |-> claimed)
        else $error("io window access not claimed");
    a_unclaimed_zero: assert property (ack && !claimed |-> rdata == '0)
        else $error("unclaimed access returned data");
    a_unaligned_zero: assert property ((in_reg && !we && addr[2:0] != 3'h0) ##1 ack
        |-> rdata == '0)
        else $error("unaligned register read returned data");
    a_reg_hi_lanes: assert property (in_reg |-> be[7:4] == 4'h0)
        else $error("upper lanes enabled on register access");
    a_reserved_bits: assert property (in_reg && we |-> wdata[31:24] == 8'h00)
        else $error("reserved bits written as one");
    a_clear_full: assert property (in_reg && !we && addr[16:0] == 17'h0_0008
        |-> be[3:0] == 4'hf)
        else $error("partial read of read-clear register");
endmodule

// *** sim/testbench.sv ***
// self-checking bench joining host end and device end
`timescale 1ns/100ps
module testbench;
    localparam int FAW = 16;
    localparam logic [31:0] REG_B = 32'h0010_0000;
    localparam logic [31:0] FL_B = 32'h0004_0000;
    localparam logic [31:0] ER_B = 32'h0008_0000;
    localparam logic [31:0] IO_B = 32'h0000_1000;
    localparam hrad_pkg::hrad_space_t MEM = hrad_pkg::HRAD_SPACE_MEM;
    localparam hrad_pkg::hrad_space_t IO = hrad_pkg::HRAD_SPACE_IO;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [31:0] fl_base = FL_B;
    logic [31:0] er_base = ER_B;
    logic fl_en = 1'b1;
    logic er_en = 1'b1;
    logic load_valid = 1'b0;
    logic [3:0] load_idx = 4'h0;
    logic [31:0] load_data = '0;
    logic [31:0] cause_set = '0;
    logic cause_pending;
    logic [31:0] ctrl_word;
    logic f_req;
    logic f_we;
    logic f_done = 1'b0;
    logic [FAW-1:0] f_addr;
    logic [7:0] f_be;
    logic [63:0] f_rdata;
    logic [1:0] fcnt = 2'h0;
    logic [FAW-1:0] seen_addr;
    logic [7:0] seen_be;
    logic [63:0] f_wdata;
    logic seen_we;
    logic [63:0] seen_wdata;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    hrad_pkg::hrad_space_t cmd_space = MEM;
    logic [31:0] cmd_addr = '0;
    logic [7:0] cmd_be = 8'h00;
    logic cmd_write = 1'b0;
    logic [63:0] cmd_wdata = '0;
    logic res_valid;
    logic res_claimed;
    logic res_refused;
    logic [63:0] res_rdata;
    logic got_cl;
    logic got_rf;
    logic [63:0] got;
    logic [63:0] fp;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;
    hrad_if bus ();
    hrad_dev_end #(.FLASH_AW(FAW)) u_hrad_dev_end (.CLK_SYS(clk_sys), .RST(rst), .BUS(bus),
        .CFG_REG_BASE(REG_B), .CFG_FLASH_BASE(fl_base), .CFG_EROM_BASE(er_base),
        .CFG_IO_BASE(IO_B), .CFG_FLASH_EN(fl_en), .CFG_EROM_EN(er_en), .LOAD_VALID(load_valid),
        .LOAD_IDX(load_idx), .LOAD_DATA(load_data), .CAUSE_SET(cause_set),
        .CAUSE_PENDING(cause_pending), .CTRL_WORD(ctrl_word), .FLASH_REQ(f_req), .FLASH_WE(f_we),
        .FLASH_ADDR(f_addr), .FLASH_BE(f_be), .FLASH_WDATA(f_wdata), .FLASH_RDATA(f_rdata),
        .FLASH_DONE(f_done));
    hrad_host_end u_hrad_host_end (.CLK_SYS(clk_sys), .RST(rst), .BUS(bus), .CFG_REG_BASE(REG_B),
        .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_SPACE(cmd_space), .CMD_ADDR(cmd_addr),
        .CMD_BE(cmd_be), .CMD_WRITE(cmd_write), .CMD_WDATA(cmd_wdata), .RES_VALID(res_valid),
        .RES_CLAIMED(res_claimed), .RES_REFUSED(res_refused), .RES_RDATA(res_rdata));
    hrad_props #(.REG_BASE(REG_B), .IO_BASE(IO_B)) u_hrad_props (.CLK_SYS(clk_sys), .RST(rst),
        .req(bus.req), .space(bus.space), .addr(bus.addr), .be(bus.be), .we(bus.we),
        .wdata(bus.wdata), .ack(bus.ack), .claimed(bus.claimed), .rdata(bus.rdata));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    function automatic logic [63:0] fpat(input logic [FAW-1:0] a);
        fpat = {16'ha5a5, a, 16'h5a5a, ~a};
    endfunction
    // flash answers after three cycles, data lines scrambled otherwise
    assign f_rdata = f_done ? fpat(f_addr) : ~fpat(f_addr);
    always @(posedge clk_sys) begin
        f_done <= f_req && !f_done && fcnt == 2'h2;
        fcnt <= (f_req && !f_done && fcnt != 2'h2) ? fcnt + 2'h1 : 2'h0;
        if (f_req) begin
            seen_addr <= f_addr;
            seen_be <= f_be;
            seen_we <= f_we;
            seen_wdata <= f_wdata;
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            final_report();
        end
    end
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] seen);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cmd(input hrad_pkg::hrad_space_t sp, input logic [31:0] a,
                       input logic [7:0] b, input logic w, input logic [63:0] d);
        int n;
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_space <= sp;
        cmd_addr <= a;
        cmd_be <= b;
        cmd_write <= w;
        cmd_wdata <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (cmd_ready !== 1'b1 && n < 50);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (res_valid !== 1'b1 && n < 50);
        chk("result valid", 64'h1, 64'(res_valid));
        got = res_rdata;
        got_cl = res_claimed;
        got_rf = res_refused;
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk("ctrl reset", '0, 64'(ctrl_word));
        cmd(MEM, REG_B, 8'hff, 1'b1, 64'hdead_beef_1234_5678);
        chk("ctrl word", 64'h0034_5678, 64'(ctrl_word));
        cmd(MEM, REG_B + 32'h10, 8'h03, 1'b1, 64'h0000_abcd);
        cmd(MEM, REG_B + 32'h10, 8'h0f, 1'b0, '0);
        chk("partial write", '0, 64'(got[31:0]));
        cmd(MEM, REG_B, 8'h01, 1'b0, '0);
        chk("partial read", 64'h0034_5678, 64'(got[31:0]));
        cmd(MEM, REG_B + 32'h70, 8'h0f, 1'b1, 64'h1);
        chk("undefined write", 64'h1, 64'(got_rf));
        cmd(MEM, REG_B + 32'h70, 8'h0f, 1'b0, '0);
        chk("undefined read", '0, got);
        cmd(MEM, REG_B + 32'h4, 8'hff, 1'b0, '0);
        chk("unaligned read", '0, got);
        cmd(MEM, 32'h00f0_0000, 8'h0f, 1'b0, '0);
        chk("unmapped claim", '0, 64'(got_cl));
        $display("test registers done");
        load_valid <= 1'b1;
        load_idx <= 4'h3;
        load_data <= 32'hcafe_f00d;
        @(posedge clk_sys);
        load_valid <= 1'b0;
        cmd(MEM, REG_B + 32'h18, 8'h0f, 1'b0, '0);
        chk("loaded value", 64'hcafe_f00d, 64'(got[31:0]));
        cause_set <= 32'h0000_0081;
        @(posedge clk_sys);
        cause_set <= '0;
        @(posedge clk_sys);
        chk("cause pending", 64'h1, 64'(cause_pending));
        cmd(MEM, REG_B + 32'h8, 8'h01, 1'b0, '0);
        chk("cause read", 64'h81, 64'(got[31:0]));
        cmd(MEM, REG_B + 32'h8, 8'h0f, 1'b0, '0);
        chk("cause cleared", '0, 64'({cause_pending, got[31:0]}));
        $display("test load and clear done");
        for (int k = 0; k < 8; k++) begin
            fl_en <= k[0];
            er_en <= k[0];
            fl_base <= k[1] ? FL_B : '0;
            er_base <= k[1] ? ER_B : '0;
            cmd(MEM, (k[2] ? ER_B : FL_B) + 32'h0128, k[2] ? 8'hff : 8'h02, 1'b0, '0);
            chk("flash claim", 64'(k[0] & k[1]), 64'(got_cl));
            chk("flash data", (k[0] & k[1]) ? fpat(16'h0128) : '0, got);
            if (k[1:0] == 2'h3) begin
                chk("flash offset", 64'h0128, 64'(seen_addr));
                chk("flash lanes", k[2] ? 64'hff : 64'h02, 64'(seen_be));
                chk("flash read dir", '0, 64'(seen_we));
            end
        end
        cmd(MEM, FL_B + 32'h0001_0000, 8'h0f, 1'b0, '0);
        chk("outside flash", '0, 64'(got_cl));
        cmd(MEM, ER_B + 32'h0203, 8'h08, 1'b1, 64'h5500_0000);
        chk("byte write lanes", 64'h08, 64'(seen_be));
        chk("flash write dir", 64'h1, 64'(seen_we));
        chk("flash wdata", 64'h5500_0000, seen_wdata);
        $display("test flash windows done");
        cmd(IO, IO_B, 8'h0f, 1'b1, 64'h0010);
        cmd(IO, IO_B + 32'h4, 8'hf0, 1'b1, 64'h8765_4321_0000_0000);
        cmd(MEM, REG_B + 32'h10, 8'h0f, 1'b0, '0);
        chk("io write", 64'h8765_4321, 64'(got[31:0]));
        cmd(IO, IO_B + 32'h4, 8'hf0, 1'b0, '0);
        chk("io read", 64'h8765_4321, 64'(got[63:32]));
        cmd(IO, IO_B, 8'h0f, 1'b1, 64'h0008_0024);
        cmd(IO, IO_B + 32'h4, 8'hf0, 1'b0, '0);
        fp = fpat(16'h0024);
        chk("io flash read", 64'(fp[63:32]), 64'(got[63:32]));
        chk("io flash offset", 64'h0024, 64'(seen_addr));
        cmd(IO, IO_B, 8'h0f, 1'b0, '0);
        chk("io pointer", 64'h0008_0024, 64'(got[31:0]));
        cmd(IO, IO_B + 32'h4, 8'h30, 1'b1, 64'h0000_beef_0000_0000);
        chk("io flash lanes", 64'h30, 64'(seen_be));
        chk("io flash wdata", 64'h0000_beef_0000_beef, seen_wdata);
        cmd(IO, IO_B, 8'h0f, 1'b1, 64'h0003_0000);
        cmd(IO, IO_B, 8'h03, 1'b1, 64'h0010);
        cmd(IO, IO_B + 32'h4, 8'hf0, 1'b0, '0);
        chk("io undefined", 64'h1, {got[63:1], got_cl});
        $display("test io window done");
        final_report();
    end
endmodule
